// >>> logic/tc_pkg.sv
package tc_pkg;
    localparam int CC_MAX = 8;
    localparam int CHAN_COUNT = 256;
    localparam int ADDR_W = 12;
    // task triggers
    localparam logic [11:0] OFF_START = 12'h000;
    localparam logic [11:0] OFF_STOP = 12'h004;
    localparam logic [11:0] OFF_COUNT = 12'h008;
    localparam logic [11:0] OFF_CLEAR = 12'h00C;
    localparam logic [11:0] OFF_HALT = 12'h010;
    localparam logic [11:0] OFF_CAPTURE = 12'h040;
    // subscriptions, events, publications and shortcuts
    localparam logic [11:0] OFF_SUB_START = 12'h080;
    localparam logic [11:0] OFF_SUB_STOP = 12'h084;
    localparam logic [11:0] OFF_SUB_COUNT = 12'h088;
    localparam logic [11:0] OFF_SUB_CLEAR = 12'h08C;
    localparam logic [11:0] OFF_SUB_HALT = 12'h090;
    localparam logic [11:0] OFF_SUB_CAPTURE = 12'h0C0;
    localparam logic [11:0] OFF_EVENT = 12'h140;
    localparam logic [11:0] OFF_PUBLISH = 12'h1C0;
    localparam logic [11:0] OFF_EVENT_TASK_SHORTCUTS = 12'h200;
    // interrupt enables
    localparam logic [11:0] OFF_IRQ_EN = 12'h300;
    localparam logic [11:0] OFF_IRQ_SET = 12'h304;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
    // configuration
    localparam logic [11:0] OFF_MODE = 12'h504;
    localparam logic [11:0] OFF_WIDTH = 12'h508;
    localparam logic [11:0] OFF_DIVIDER = 12'h510;
    localparam logic [11:0] OFF_MATCH = 12'h540;
    localparam logic [11:0] OFF_SINGLE = 12'h580;
    // field positions
    localparam int LINK_EN_BIT = 31;
    localparam int IRQ_MATCH_BASE = 16;
    // values after reset
    localparam logic [3:0] DIVIDER_RESET = 4'h4;
    localparam logic [1:0] WIDTH_RESET = 2'h0;
    localparam logic [1:0] MODE_RESET = 2'h0;
    // width select encodings
    localparam logic [1:0] WIDTH_16 = 2'h0;
    localparam logic [1:0] WIDTH_8 = 2'h1;
    localparam logic [1:0] WIDTH_24 = 2'h2;
    localparam logic [1:0] WIDTH_32 = 2'h3;
    // prescaler value from which the slow clock suffices
    localparam logic [3:0] SLOW_CLOCK_MIN_DIV = 4'h4;
    localparam int DIV_W = 15;
endpackage

// >>> logic/timer_counter_capture_compare.sv
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - tick rate is clock over two-power prescaler
// - slow clock selected when tick rate low
// - start runs, stop halts, resume keeps count
// - timer mode adds one per tick
// - counter mode adds one per count task
// - count task ignored in timer mode
// - width select sets maximum count
// - count wraps to zero past maximum
// - clear task zeroes count
// - capture task n copies count to n
// - compare event when increment hits value
// - compare uses only selected low bits
// - one-shot fires once per value write
// - clear, count, stop act within one cycle
// - stop wins over simultaneous start
// - capture sees count before clear
// - resolution is one prescaled tick
// - enable register plus set and clear
// - subscription holds channel index and enable
module timer_counter_capture_compare #(
    parameter int N_CC = 6
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire logic [tc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // event interconnect
    input wire logic [tc_pkg::CHAN_COUNT-1:0] chan_in,
    output logic [tc_pkg::CHAN_COUNT-1:0] chan_out,
    // status toward the system
    output logic irq_request,
    output logic slow_clock_select,
    output logic running_out
);
    import tc_pkg::*;

    function automatic logic [31:0] width_mask(input logic [1:0] sel);
        unique case (sel)
            WIDTH_8: width_mask = 32'h000000FF;
            WIDTH_16: width_mask = 32'h0000FFFF;
            WIDTH_24: width_mask = 32'h00FFFFFF;
            WIDTH_32: width_mask = 32'hFFFFFFFF;
        endcase
    endfunction

    // a subscription fires when enabled and its channel pulses
    function automatic logic link_hit(input logic [31:0] link,
                                      input logic [CHAN_COUNT-1:0] ch);
        link_hit = link[LINK_EN_BIT] && ch[link[7:0]];
    endfunction

    // configuration and state
    logic running;
    logic [31:0] count;
    logic [DIV_W-1:0] div_cnt;
    logic [1:0] mode;
    logic [1:0] width_sel;
    logic [3:0] divider;
    logic [31:0] irq_en;
    logic [31:0] event_task_shortcuts;
    logic [31:0] sub_start, sub_stop, sub_count, sub_clear, sub_halt;
    logic [31:0] sub_cap [N_CC];
    logic [31:0] pub [N_CC];
    logic [31:0] match [N_CC];
    logic [N_CC-1:0] single_en;
    logic [N_CC-1:0] armed;
    logic [N_CC-1:0] events;

    logic [31:0] next_count;
    logic next_running;
    logic [DIV_W-1:0] next_div_cnt;
    logic [1:0] next_mode, next_width_sel;
    logic [3:0] next_divider;
    logic [31:0] next_irq_en, next_event_task_shortcuts;
    logic [31:0] next_sub_start, next_sub_stop, next_sub_count;
    logic [31:0] next_sub_clear, next_sub_halt;
    logic [31:0] next_sub_cap [N_CC];
    logic [31:0] next_pub [N_CC];
    logic [31:0] next_match [N_CC];
    logic [N_CC-1:0] next_single_en, next_armed, next_events;
    logic [CHAN_COUNT-1:0] next_chan_out;
    logic [31:0] next_rdata;

    // task strobes from software and from the interconnect
    logic wr_one;
    logic t_start, t_stop, t_count, t_clear;
    logic [N_CC-1:0] t_cap;
    logic [N_CC-1:0] fire;
    logic tick, inc;
    logic [31:0] mask, inc_val;
    logic [DIV_W-1:0] pmask;

    assign wr_one = reg_wr && reg_wdata[0];

    always_comb begin
        t_start = (wr_one && reg_addr == OFF_START)
            || link_hit(sub_start, chan_in);
        // legacy halt acts as a stop
        t_stop = (wr_one && (reg_addr == OFF_STOP || reg_addr == OFF_HALT))
            || link_hit(sub_stop, chan_in) || link_hit(sub_halt, chan_in);
        t_count = (wr_one && reg_addr == OFF_COUNT)
            || link_hit(sub_count, chan_in);
        t_clear = (wr_one && reg_addr == OFF_CLEAR)
            || link_hit(sub_clear, chan_in);
        for (int n = 0; n < N_CC; n++) begin
            t_cap[n] = (wr_one
                && reg_addr == OFF_CAPTURE + ADDR_W'(4 * n))
                || link_hit(sub_cap[n], chan_in);
        end
    end

    // prescaled tick: every 2^divider cycles while running in timer mode
    always_comb begin
        pmask = DIV_W'((32'h1 << divider) - 32'h1);
        tick = running && mode == MODE_RESET
            && ((div_cnt & pmask) == pmask);
        mask = width_mask(width_sel);
        // count task only counts outside timer mode
        inc = running && (mode == MODE_RESET ? tick : t_count);
        inc_val = (count + 32'h1) & mask;
    end
    // low tick rates run from the slow clock to save power
    assign slow_clock_select = divider >= SLOW_CLOCK_MIN_DIV;
    assign running_out = running;

    // counter, run state and compare
    always_comb begin
        next_running = running;
        if (t_start) begin
            next_running = 1'b1;
        end
        if (t_stop) begin
            next_running = 1'b0;
        end
        next_div_cnt = running ? div_cnt + DIV_W'(1) : div_cnt;
        next_count = count;
        if (t_clear) begin
            next_count = 32'h0;
        end else if (inc) begin
            next_count = inc_val;
        end
        for (int n = 0; n < N_CC; n++) begin
            fire[n] = inc && !t_clear
                && ((inc_val ^ match[n]) & mask) == 32'h0
                && (!single_en[n] || armed[n]);
        end
    end

    // register writes, captures, sticky events
    always_comb begin
        next_mode = mode;
        next_width_sel = width_sel;
        next_divider = divider;
        next_irq_en = irq_en;
        next_event_task_shortcuts = event_task_shortcuts;
        next_sub_start = sub_start;
        next_sub_stop = sub_stop;
        next_sub_count = sub_count;
        next_sub_clear = sub_clear;
        next_sub_halt = sub_halt;
        next_single_en = single_en;
        next_armed = armed;
        next_events = events;
        next_chan_out = '0;
        if (reg_wr) begin
            unique case (reg_addr)
                OFF_MODE: next_mode = reg_wdata[1:0];
                OFF_WIDTH: next_width_sel = reg_wdata[1:0];
                OFF_DIVIDER: next_divider = reg_wdata[3:0];
                OFF_IRQ_EN: next_irq_en = reg_wdata;
                OFF_IRQ_SET: next_irq_en = irq_en | reg_wdata;
                OFF_IRQ_CLR: next_irq_en = irq_en & ~reg_wdata;
                OFF_EVENT_TASK_SHORTCUTS: next_event_task_shortcuts = reg_wdata;
                OFF_SUB_START: next_sub_start = reg_wdata;
                OFF_SUB_STOP: next_sub_stop = reg_wdata;
                OFF_SUB_COUNT: next_sub_count = reg_wdata;
                OFF_SUB_CLEAR: next_sub_clear = reg_wdata;
                OFF_SUB_HALT: next_sub_halt = reg_wdata;
                default: ;
            endcase
        end
        for (int n = 0; n < N_CC; n++) begin
            next_sub_cap[n] = sub_cap[n];
            next_pub[n] = pub[n];
            next_match[n] = match[n];
            if (reg_wr) begin
                if (reg_addr == OFF_SUB_CAPTURE + ADDR_W'(4 * n)) begin
                    next_sub_cap[n] = reg_wdata;
                end
                if (reg_addr == OFF_PUBLISH + ADDR_W'(4 * n)) begin
                    next_pub[n] = reg_wdata;
                end
                if (reg_addr == OFF_SINGLE + ADDR_W'(4 * n)) begin
                    next_single_en[n] = reg_wdata[0];
                end
                if (reg_addr == OFF_MATCH + ADDR_W'(4 * n)) begin
                    next_match[n] = reg_wdata;
                    next_armed[n] = 1'b1;
                end
                // only a written zero clears; a new hit still wins
                if (reg_addr == OFF_EVENT + ADDR_W'(4 * n)
                    && !reg_wdata[0]) begin
                    next_events[n] = 1'b0;
                end
            end
            // capture takes the count before any clear this cycle
            if (t_cap[n]) begin
                next_match[n] = count;
            end
            if (fire[n]) begin
                next_events[n] = 1'b1;
                if (single_en[n] && !(reg_wr
                        && reg_addr == OFF_MATCH + ADDR_W'(4 * n))) begin
                    next_armed[n] = 1'b0;
                end
                if (pub[n][LINK_EN_BIT]) begin
                    next_chan_out[pub[n][7:0]] = 1'b1;
                end
            end
        end
    end

    // interrupt only through the enable bit of each event
    always_comb begin
        irq_request = 1'b0;
        for (int n = 0; n < N_CC; n++) begin
            irq_request = irq_request
                || (events[n] && irq_en[IRQ_MATCH_BASE + n]);
        end
    end

    // read mux; trigger registers read as zero
    always_comb begin
        next_rdata = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFF_MODE: next_rdata = {30'h0, mode};
                OFF_WIDTH: next_rdata = {30'h0, width_sel};
                OFF_DIVIDER: next_rdata = {28'h0, divider};
                OFF_IRQ_EN, OFF_IRQ_SET, OFF_IRQ_CLR: next_rdata = irq_en;
                OFF_EVENT_TASK_SHORTCUTS: next_rdata = event_task_shortcuts;
                OFF_SUB_START: next_rdata = sub_start;
                OFF_SUB_STOP: next_rdata = sub_stop;
                OFF_SUB_COUNT: next_rdata = sub_count;
                OFF_SUB_CLEAR: next_rdata = sub_clear;
                OFF_SUB_HALT: next_rdata = sub_halt;
                default: ;
            endcase
            for (int n = 0; n < N_CC; n++) begin
                if (reg_addr == OFF_SUB_CAPTURE + ADDR_W'(4 * n)) begin
                    next_rdata = sub_cap[n];
                end
                if (reg_addr == OFF_PUBLISH + ADDR_W'(4 * n)) begin
                    next_rdata = pub[n];
                end
                if (reg_addr == OFF_MATCH + ADDR_W'(4 * n)) begin
                    next_rdata = match[n];
                end
                if (reg_addr == OFF_SINGLE + ADDR_W'(4 * n)) begin
                    next_rdata = {31'h0, single_en[n]};
                end
                if (reg_addr == OFF_EVENT + ADDR_W'(4 * n)) begin
                    next_rdata = {31'h0, events[n]};
                end
            end
        end
    end

    // all state registers; synchronous reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            running <= 1'b0;
            count <= 32'h0;
            mode <= MODE_RESET;
            div_cnt <= '0;
            width_sel <= WIDTH_RESET;
            divider <= DIVIDER_RESET;
            irq_en <= 32'h0;
            event_task_shortcuts <= 32'h0;
            sub_start <= 32'h0;
            sub_stop <= 32'h0;
            sub_count <= 32'h0;
            sub_clear <= 32'h0;
            sub_halt <= 32'h0;
            single_en <= '0;
            armed <= '0;
            events <= '0;
            chan_out <= '0;
            reg_rdata <= 32'h0;
            for (int n = 0; n < N_CC; n++) begin
                sub_cap[n] <= 32'h0;
                pub[n] <= 32'h0;
                match[n] <= 32'h0;
            end
        end else begin
            running <= next_running;
            count <= next_count;
            mode <= next_mode;
            div_cnt <= next_div_cnt;
            width_sel <= next_width_sel;
            divider <= next_divider;
            irq_en <= next_irq_en;
            event_task_shortcuts <= next_event_task_shortcuts;
            sub_start <= next_sub_start;
            sub_stop <= next_sub_stop;
            sub_count <= next_sub_count;
            sub_clear <= next_sub_clear;
            sub_halt <= next_sub_halt;
            single_en <= next_single_en;
            armed <= next_armed;
            events <= next_events;
            chan_out <= next_chan_out;
            reg_rdata <= next_rdata;
            for (int n = 0; n < N_CC; n++) begin
                sub_cap[n] <= next_sub_cap[n];
                pub[n] <= next_pub[n];
                match[n] <= next_match[n];
            end
        end
    end

    // checks
    property p_stop_wins;
        @(posedge core_clk) disable iff (!nrst)
        t_start && t_stop |=> !running;
    endproperty
    a_stop_wins: assert property (p_stop_wins)
        else $error("stop did not win over start");

    property p_clear_zero;
        @(posedge core_clk) disable iff (!nrst)
        t_clear |=> count == 32'h0;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("clear did not zero the count");

    property p_capture_pre_clear;
        @(posedge core_clk) disable iff (!nrst)
        t_cap[0] |=> match[0] == $past(count);
    endproperty
    a_capture_pre_clear: assert property (p_capture_pre_clear)
        else $error("capture stored wrong count");

    property p_timer_ignores_count;
        @(posedge core_clk) disable iff (!nrst)
        mode == MODE_RESET && !tick && !t_clear |=> $stable(count);
    endproperty
    a_timer_ignores_count: assert property (p_timer_ignores_count)
        else $error("count moved without a tick");

    property p_fast_tick;
        @(posedge core_clk) disable iff (!nrst)
        running && mode == MODE_RESET && divider == 4'h0
            && width_sel == WIDTH_32 && !t_clear && !t_stop
        |=> count == $past(count) + 32'h1;
    endproperty
    a_fast_tick: assert property (p_fast_tick)
        else $error("undivided timer missed a tick");

    property p_wrap;
        @(posedge core_clk) disable iff (!nrst)
        inc && !t_clear && (count & mask) == mask |=> count == 32'h0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("count did not wrap to zero");

    property p_event_sticky;
        @(posedge core_clk) disable iff (!nrst)
        events[0] && !(reg_wr && reg_addr == OFF_EVENT) |=> events[0];
    endproperty
    a_event_sticky: assert property (p_event_sticky)
        else $error("event dropped without a clear");

    property p_oneshot;
        @(posedge core_clk) disable iff (!nrst)
        fire[0] && single_en[0] && !(reg_wr && reg_addr == OFF_MATCH)
        |=> !armed[0] ##1 !fire[0] || armed[0];
    endproperty
    a_oneshot: assert property (p_oneshot)
        else $error("one-shot compare fired twice");

    property p_reset_state;
        @(posedge core_clk)
        !nrst |=> !running && count == 32'h0 && mode == MODE_RESET;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset state wrong");
endmodule

`default_nettype wire

// >>> testbench/event_link_model.sv
`timescale 1ns/1ns
`default_nettype none

module event_link_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // request from the bench
    input wire logic fire,
    input wire logic [7:0] fire_idx,
    // interconnect lines
    output logic [tc_pkg::CHAN_COUNT-1:0] chan_in,
    input wire logic [tc_pkg::CHAN_COUNT-1:0] chan_out,
    // observation
    output int pub_count
);
    // one-cycle pulse just after the edge; idle channels sit low
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            chan_in <= '0;
        end else if (fire) begin
            chan_in <= {{(tc_pkg::CHAN_COUNT-1){1'b0}}, 1'b1} << fire_idx;
        end else begin
            chan_in <= '0;
        end
    end

    // tally published compare pulses on any channel
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pub_count <= 0;
        end else if (|chan_out) begin
            pub_count <= pub_count + 1;
        end
    end
endmodule

`default_nettype wire

// >>> testbench/timer_counter_capture_compare_tb.sv
`timescale 1ns/1ns
`default_nettype none

module timer_counter_capture_compare_tb;
    import tc_pkg::*;
    typedef struct {logic [31:0] v; logic [31:0] tol;} exp_s;
    logic core_clk;
    logic nrst;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [CHAN_COUNT-1:0] chan_in;
    logic [CHAN_COUNT-1:0] chan_out;
    logic irq_request;
    logic slow_clock_select;
    logic running_out;
    logic fire;
    logic [7:0] fire_idx;
    logic rd_seen;
    logic [31:0] seed;
    int pub_count;
    int pub_exp;
    int n_errors;
    int num_checks;
    int n;
    exp_s exp_q[$];

    timer_counter_capture_compare #(.N_CC(6)) dut (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .chan_in(chan_in), .chan_out(chan_out),
        .irq_request(irq_request), .slow_clock_select(slow_clock_select),
        .running_out(running_out)
    );

    event_link_model link (
        .core_clk(core_clk), .nrst(nrst), .fire(fire),
        .fire_idx(fire_idx), .chan_in(chan_in), .chan_out(chan_out),
        .pub_count(pub_count)
    );

    // free-running bench clock, 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // every bus signal set once per edge, so back-to-back calls never race
    task automatic bus(input logic w, input logic r, input logic [11:0] a,
                       input logic [31:0] d, input int fc);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        fire <= (fc >= 0);
        fire_idx <= fc[7:0];
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d, -1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] t);
        exp_q.push_back('{e, t});
        bus(1'b0, 1'b1, a, 32'h00000000, -1);
    endtask

    task automatic idle(input int k);
        repeat (k) bus(1'b0, 1'b0, 12'h000, 32'h00000000, -1);
    endtask

    task automatic check_val(input logic [31:0] got, input exp_s e);
        num_checks++;
        if (^got === 1'bx || got + e.tol < e.v || got > e.v + e.tol) begin
            $display("unexpected read at %0t: got %h expected %h",
                     $time, got, e.v);
            n_errors++;
        end
    endtask

    // flags are sampled mid-cycle, once the edge's updates have landed
    task automatic check_flag(input int sel, input logic e);
        logic got;
        @(negedge core_clk);
        got = sel == 0 ? running_out : sel == 1 ? slow_clock_select :
              sel == 2 ? irq_request : (pub_count == pub_exp);
        num_checks++;
        if (got !== e) begin
            $display("unexpected flag %0d at %0t: got %h expected %h",
                     sel, $time, got, e);
            n_errors++;
        end
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge core_clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                $display("unexpected read at %0t: got %h expected %h",
                         $time, reg_rdata, 32'h00000000);
                n_errors++;
            end else begin
                check_val(reg_rdata, exp_q.pop_front());
            end
        end
        rd_seen <= reg_rd;
    end

    // hang guard well beyond the scripted run
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        summarize();
    end

    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h00000000;
        fire = 1'b0;
        fire_idx = 8'h00;
        n_errors = 0;
        num_checks = 0;
        pub_exp = 1;
        seed = 32'h0000F21A;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        check_flag(0, 1'b0);
        check_flag(1, 1'b1);
        rd(OFF_MODE, 32'h00000000, 0);
        rd(OFF_DIVIDER, {28'h0000000, DIVIDER_RESET}, 0);
        rd(OFF_WIDTH, 32'h00000000, 0);
        rd(12'hFFC, 32'h00000000, 0);
        rd(OFF_START, 32'h00000000, 0);
        wr(OFF_CAPTURE, 32'h00000001);
        idle(1);
        rd(OFF_MATCH, 32'h00000000, 0);
        // prescaler 2: one tick per four clocks
        wr(OFF_DIVIDER, 32'h00000002);
        wr(OFF_START, 32'h00000001);
        idle(1);
        check_flag(0, 1'b1);
        check_flag(1, 1'b0);
        idle(39);
        wr(OFF_STOP, 32'h00000001);
        idle(1);
        check_flag(0, 1'b0);
        wr(OFF_CAPTURE, 32'h00000001);
        idle(1);
        rd(OFF_MATCH, 32'h0000000A, 1);
        idle(20);
        wr(OFF_CAPTURE, 32'h00000001);
        idle(1);
        rd(OFF_MATCH, 32'h0000000A, 1);
        wr(OFF_START, 32'h00000001);
        idle(40);
        wr(OFF_STOP, 32'h00000001);
        wr(OFF_CAPTURE, 32'h00000001);
        idle(1);
        rd(OFF_MATCH, 32'h00000014, 2);
        // slowest tick never lands here and timer mode ignores count tasks, so the count stays zero
        wr(OFF_DIVIDER, 32'h0000000F);
        wr(OFF_CLEAR, 32'h00000001);
        wr(OFF_START, 32'h00000001);
        repeat (4) wr(OFF_COUNT, 32'h00000001);
        wr(OFF_STOP, 32'h00000001);
        wr(OFF_CAPTURE, 32'h00000001);
        idle(1);
        rd(OFF_MATCH, 32'h00000000, 0);
        // counter mode with a random number of count tasks
        wr(OFF_MODE, 32'h00000001);
        wr(OFF_START, 32'h00000001);
        seed = xorshift(seed);
        n = int'(seed[4:0]) + 1;
        repeat (n) wr(OFF_COUNT, seed | 32'h00000001);
        wr(OFF_COUNT, 32'h00000000);
        wr(OFF_CAPTURE + 12'h014, 32'h00000001);
        idle(1);
        rd(OFF_MATCH + 12'h014, n, 0);
        // capture from the interconnect in the same cycle as clear
        wr(OFF_SUB_CAPTURE, 32'h80000007);
        bus(1'b0, 1'b0, 12'h000, 32'h00000000, 7);
        wr(OFF_CLEAR, 32'h00000001);
        idle(1);
        rd(OFF_MATCH, n, 0);
        wr(OFF_CAPTURE, 32'h00000001);
        idle(1);
        rd(OFF_MATCH, 32'h00000000, 0);
        // start via channel 5 against a software stop
        wr(OFF_STOP, 32'h00000001);
        wr(OFF_SUB_START, 32'h80000005);
        bus(1'b0, 1'b0, 12'h000, 32'h00000000, 5);
        wr(OFF_STOP, 32'h00000001);
        idle(1);
        check_flag(0, 1'b0);
        bus(1'b0, 1'b0, 12'h000, 32'h00000000, 5);
        idle(2);
        check_flag(0, 1'b1);
        wr(OFF_SUB_START, 32'h00000005);
        wr(OFF_STOP, 32'h00000001);
        bus(1'b0, 1'b0, 12'h000, 32'h00000000, 5);
        idle(2);
        check_flag(0, 1'b0);
        // 8-bit width: upper match bits ignored, wrap at 255
        wr(OFF_WIDTH, {30'h0, WIDTH_8});
        wr(OFF_CLEAR, 32'h00000001);
        wr(OFF_MATCH + 12'h004, 32'h00000103);
        wr(OFF_PUBLISH + 12'h004, 32'h80000009);
        wr(OFF_IRQ_SET, 32'h00020000);
        rd(OFF_IRQ_EN, 32'h00020000, 0);
        wr(OFF_START, 32'h00000001);
        repeat (3) wr(OFF_COUNT, 32'h00000001);
        idle(2);
        check_flag(2, 1'b1);
        check_flag(3, 1'b1);
        rd(OFF_EVENT + 12'h004, 32'h00000001, 0);
        wr(OFF_IRQ_CLR, 32'h00020000);
        idle(1);
        check_flag(2, 1'b0);
        rd(OFF_IRQ_EN, 32'h00000000, 0);
        rd(OFF_EVENT + 12'h004, 32'h00000001, 0);
        wr(OFF_EVENT + 12'h004, 32'h00000000);
        rd(OFF_EVENT + 12'h004, 32'h00000000, 0);
        // one-shot: a full lap hits once, the next lap stays silent
        wr(OFF_SINGLE + 12'h004, 32'h00000001);
        wr(OFF_MATCH + 12'h004, 32'h00000103);
        repeat (256) wr(OFF_COUNT, 32'h00000001);
        idle(1);
        rd(OFF_EVENT + 12'h004, 32'h00000001, 0);
        wr(OFF_EVENT + 12'h004, 32'h00000000);
        repeat (256) wr(OFF_COUNT, 32'h00000001);
        idle(1);
        rd(OFF_EVENT + 12'h004, 32'h00000000, 0);
        pub_exp = 2;
        check_flag(3, 1'b1);
        wr(OFF_CAPTURE + 12'h008, 32'h00000001);
        idle(1);
        rd(OFF_MATCH + 12'h008, 32'h00000003, 0);
        // one-shot on channel 0: hit at 4 once, silent a lap later
        wr(OFF_SINGLE, 32'h00000001);
        wr(OFF_MATCH, 32'h00000004);
        wr(OFF_EVENT, 32'h00000000);
        wr(OFF_COUNT, 32'h00000001);
        rd(OFF_EVENT, 32'h00000001, 0);
        wr(OFF_EVENT, 32'h00000000);
        repeat (256) wr(OFF_COUNT, 32'h00000001);
        rd(OFF_EVENT, 32'h00000000, 0);
        // undivided 32-bit timer, ended by the legacy halt task
        wr(OFF_STOP, 32'h00000001);
        wr(OFF_MODE, 32'h00000000);
        wr(OFF_WIDTH, {30'h0, WIDTH_32});
        wr(OFF_DIVIDER, 32'h00000000);
        wr(OFF_CLEAR, 32'h00000001);
        wr(OFF_START, 32'h00000001);
        idle(8);
        wr(OFF_HALT, 32'h00000001);
        idle(1);
        check_flag(0, 1'b0);
        wr(OFF_CAPTURE + 12'h00C, 32'h00000001);
        idle(1);
        rd(OFF_MATCH + 12'h00C, 32'h00000009, 0);
        idle(3);
        summarize();
    end
endmodule

`default_nettype wire
